/* src/dcc_pkg.sv */
// constants for the dac clear control register bank
`default_nettype none
package dcc_pkg;
   // dac count and the field that carries one bit per dac
   localparam int DCC_NUM_DAC = 12;
   localparam int DCC_DAC_LSB = 3;
   localparam int DCC_DAC_MSB = 14;
   // register indices as printed; byte address is four times the index
   localparam logic [7:0] DCC_IDX_SRC_SEL = 8'h53;
   localparam logic [7:0] DCC_IDX_AUTO_EN = 8'h54;
   localparam logic [7:0] DCC_IDX_SW_CLR = 8'h55;
   localparam logic [7:0] DCC_IDX_PIN0_EN = 8'h56;
   localparam logic [7:0] DCC_IDX_CLR_STATE = 8'h70;
   localparam int DCC_ADDR_W = 10;
   localparam logic [9:0] DCC_ADDR_SRC_SEL = {DCC_IDX_SRC_SEL, 2'h0};
   localparam logic [9:0] DCC_ADDR_AUTO_EN = {DCC_IDX_AUTO_EN, 2'h0};
   localparam logic [9:0] DCC_ADDR_SW_CLR = {DCC_IDX_SW_CLR, 2'h0};
   localparam logic [9:0] DCC_ADDR_PIN0_EN = {DCC_IDX_PIN0_EN, 2'h0};
   localparam logic [9:0] DCC_ADDR_CLR_STATE = {DCC_IDX_CLR_STATE, 2'h0};
   // source select bit positions, also the alarm flag positions
   localparam int DCC_SEL_IN0 = 14;
   localparam int DCC_SEL_IN1 = 13;
   localparam int DCC_SEL_IN2 = 12;
   localparam int DCC_SEL_IN3 = 11;
   localparam int DCC_SEL_LT_LOW = 10;
   localparam int DCC_SEL_LT_HIGH = 9;
   localparam int DCC_SEL_R1_LOW = 8;
   localparam int DCC_SEL_R1_HIGH = 7;
   localparam int DCC_SEL_R2_LOW = 6;
   localparam int DCC_SEL_R2_HIGH = 5;
   localparam int DCC_SEL_R1_FAIL = 4;
   localparam int DCC_SEL_R2_FAIL = 3;
   localparam int DCC_SEL_THERM = 2;
   // writable masks, the non-thermal alarm mask and reset values
   localparam logic [15:0] DCC_SRC_SEL_MASK = 16'h7ffc;
   localparam logic [15:0] DCC_SRC_SEL_RESET = 16'h0004;
   localparam logic [15:0] DCC_ALARM_MASK = 16'h7ff8;
   localparam logic [15:0] DCC_DAC_MASK = 16'h7ff8;
   localparam logic [15:0] DCC_DAC_RESET = 16'h0000;
   // axi responses
   localparam logic [1:0] DCC_RESP_OKAY = 2'h0;
   localparam logic [1:0] DCC_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* src/dcc_clear_cell.sv */
// one dac's clear decision, registered
`default_nettype none
module dcc_clear_cell
   import dcc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic alarm_hit,
   input wire logic therm_hit,
   input wire logic auto_enable,
   input wire logic soft_clear,
   input wire logic pin_enable,
   input wire logic pin_active,
   output logic clear
);
   logic next_clear; // combined clear condition

   // or of every source; therm_hit ignores the auto enable
   always_comb begin
      next_clear = (alarm_hit & auto_enable)
         | therm_hit
         | soft_clear
         | (pin_enable & pin_active);
   end

   // one flop; no sync-load gating so the clear lands on the next edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clear <= 1'b0;
      end else begin
         clear <= next_clear;
      end
   end
endmodule
`default_nettype wire

/* src/dcc_dac_clear_control.sv */
// dac clear control register bank with axi4-lite slave
`default_nettype none
module dcc_dac_clear_control
   import dcc_pkg::*;
#(
   parameter int NUM_DAC = DCC_NUM_DAC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] alarm_status_flags,
   input wire logic external_clear_pin_0_n,
   output logic [NUM_DAC-1:0] dac_clear
);

   // the dac field is fixed at 14:3, so only twelve dacs fit
   if (NUM_DAC != DCC_DAC_MSB - DCC_DAC_LSB + 1) begin : g_chk
      $error("NUM_DAC must match the 14:3 dac field");
   end

   // software visible registers
   logic [15:0] alarm_source_clear_select; // which alarms may clear
   logic [15:0] auto_clear_enable; // per_dac_auto_clear_enable
   logic [15:0] software_dac_clear; // per_dac_software_clear
   logic [15:0] pin0_clear_enable; // per_dac_pin0_clear_enable

   // write channel holding state
   logic aw_held; // write address taken
   logic [DCC_ADDR_W-1:0] aw_addr; // held write address
   logic w_held; // write data taken
   logic [15:0] w_data; // held low half of write data
   logic [1:0] w_strb; // held low lane strobes
   logic do_write; // both halves present, commit now

   // read and write side decode
   logic [15:0] rd_word; // decoded read value
   logic rd_ok; // address is mapped
   logic wr_ok; // write address is mapped

   // pin synchroniser and gating terms
   logic pin_meta; // first stage, read only by pin_sync
   logic pin_sync; // second stage
   logic pin_active; // pin driven low
   logic [15:0] sel_hits; // selected non-thermal alarms that are raised
   logic alarm_hit; // any selected non-thermal alarm
   logic therm_hit; // selected over-temperature alarm
   logic [NUM_DAC-1:0] expect_clear; // helper for the checks

   // axi ready terms; one write and one read in flight at most
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   // write address capture, released at the commit edge, as the response is raised
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr[DCC_ADDR_W-1:0];
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   // write data capture; upper lanes ignored, data is 16 bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata[15:0];
         w_strb <= s_axi_wstrb[1:0];
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   // merge held data into a register under the byte strobes
   function automatic logic [15:0] merge(input logic [15:0] old_val,
                                         input logic [15:0] new_val,
                                         input logic [1:0] strb,
                                         input logic [15:0] mask);
      logic [15:0] res;
      res = old_val;
      if (strb[0]) begin
         res[7:0] = new_val[7:0];
      end
      if (strb[1]) begin
         res[15:8] = new_val[15:8];
      end
      merge = res & mask;
   endfunction

   // write address decode on bits 9:0 only; an unmapped offset there answers slverr
   always_comb begin
      if (aw_addr == DCC_ADDR_SRC_SEL) begin
         wr_ok = 1'b1;
      end else if (aw_addr == DCC_ADDR_AUTO_EN) begin
         wr_ok = 1'b1;
      end else if (aw_addr == DCC_ADDR_SW_CLR) begin
         wr_ok = 1'b1;
      end else if (aw_addr == DCC_ADDR_PIN0_EN) begin
         wr_ok = 1'b1;
      end else if (aw_addr == DCC_ADDR_CLR_STATE) begin
         wr_ok = 1'b1; // read-only status, writes dropped
      end else begin
         wr_ok = 1'b0;
      end
   end

   // source select register; reserved bits masked off
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alarm_source_clear_select <= DCC_SRC_SEL_RESET;
      end else if (do_write && aw_addr == DCC_ADDR_SRC_SEL) begin
         alarm_source_clear_select <= merge(alarm_source_clear_select,
            w_data, w_strb, DCC_SRC_SEL_MASK);
      end
   end

   // auto clear enables, zero after reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         auto_clear_enable <= DCC_DAC_RESET;
      end else if (do_write && aw_addr == DCC_ADDR_AUTO_EN) begin
         auto_clear_enable <= merge(auto_clear_enable, w_data, w_strb,
            DCC_DAC_MASK);
      end
   end

   // software clear; a written zero releases the dac
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         software_dac_clear <= DCC_DAC_RESET;
      end else if (do_write && aw_addr == DCC_ADDR_SW_CLR) begin
         software_dac_clear <= merge(software_dac_clear, w_data, w_strb,
            DCC_DAC_MASK);
      end
   end

   // pin 0 clear enables
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin0_clear_enable <= DCC_DAC_RESET;
      end else if (do_write && aw_addr == DCC_ADDR_PIN0_EN) begin
         pin0_clear_enable <= merge(pin0_clear_enable, w_data, w_strb,
            DCC_DAC_MASK);
      end
   end

   // write response, one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= DCC_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? DCC_RESP_OKAY : DCC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read decode; status word shows the live clear outputs
   always_comb begin
      rd_word = 16'h0000;
      rd_ok = 1'b1;
      if (s_axi_araddr[DCC_ADDR_W-1:0] == DCC_ADDR_SRC_SEL) begin
         rd_word = alarm_source_clear_select;
      end else if (s_axi_araddr[DCC_ADDR_W-1:0] == DCC_ADDR_AUTO_EN) begin
         rd_word = auto_clear_enable;
      end else if (s_axi_araddr[DCC_ADDR_W-1:0] == DCC_ADDR_SW_CLR) begin
         rd_word = software_dac_clear;
      end else if (s_axi_araddr[DCC_ADDR_W-1:0] == DCC_ADDR_PIN0_EN) begin
         rd_word = pin0_clear_enable;
      end else if (s_axi_araddr[DCC_ADDR_W-1:0] == DCC_ADDR_CLR_STATE) begin
         rd_word[DCC_DAC_MSB:DCC_DAC_LSB] = dac_clear;
      end else begin
         rd_ok = 1'b0; // unmapped reads return zero with slverr
      end
      if (s_axi_araddr[31:DCC_ADDR_W] != '0) begin
         rd_ok = 1'b0;
         rd_word = 16'h0000;
      end
   end

   // read data channel, answers one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= DCC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {16'h0000, rd_word};
         s_axi_rresp <= rd_ok ? DCC_RESP_OKAY : DCC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // the pin is asynchronous to aclk; two flops before any use
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta <= 1'b1;
         pin_sync <= 1'b1;
      end else begin
         pin_meta <= external_clear_pin_0_n;
         pin_sync <= pin_meta;
      end
   end
   assign pin_active = !pin_sync;

   // alarm gating; flag bits share the select bit layout, so
   // bit 4 pairs with the remote 1 failure flag
   always_comb begin
      sel_hits = alarm_source_clear_select & alarm_status_flags
         & DCC_ALARM_MASK;
      alarm_hit = sel_hits[DCC_SEL_IN0] | sel_hits[DCC_SEL_IN1]
         | sel_hits[DCC_SEL_IN2]
         | sel_hits[DCC_SEL_IN3]
         | sel_hits[DCC_SEL_LT_LOW] | sel_hits[DCC_SEL_LT_HIGH]
         | sel_hits[DCC_SEL_R1_LOW] | sel_hits[DCC_SEL_R1_HIGH]
         | sel_hits[DCC_SEL_R2_LOW] | sel_hits[DCC_SEL_R2_HIGH]
         | sel_hits[DCC_SEL_R1_FAIL]
         | sel_hits[DCC_SEL_R2_FAIL];
      therm_hit = alarm_source_clear_select[DCC_SEL_THERM]
         & alarm_status_flags[DCC_SEL_THERM];
   end

   // one clear cell per dac
   for (genvar i = 0; i < NUM_DAC; i++) begin : g_dac
      dcc_clear_cell u_cell (
         .aclk(aclk),
         .aresetn(aresetn),
         .alarm_hit(alarm_hit),
         .therm_hit(therm_hit),
         .auto_enable(auto_clear_enable[DCC_DAC_LSB+i]),
         .soft_clear(software_dac_clear[DCC_DAC_LSB+i]),
         .pin_enable(pin0_clear_enable[DCC_DAC_LSB+i]),
         .pin_active(pin_active),
         .clear(dac_clear[i])
      );
      // helper for the checks below
      assign expect_clear[i] = (alarm_hit
         & auto_clear_enable[DCC_DAC_LSB+i]) | therm_hit
         | software_dac_clear[DCC_DAC_LSB+i]
         | (pin0_clear_enable[DCC_DAC_LSB+i] & pin_active);
   end

   // checks on the clear outputs, the register contents and the write response
   a_clear_equation: assert property (@(posedge aclk) disable iff
      (!aresetn) $past(aresetn) |-> dac_clear == $past(expect_clear))
      else $error("dac clear differs from combined sources");

   a_therm_all_clear: assert property (@(posedge aclk) disable iff
      (!aresetn) alarm_source_clear_select[DCC_SEL_THERM]
      && alarm_status_flags[DCC_SEL_THERM] |=> &dac_clear)
      else $error("over-temperature did not clear every dac");

   a_unselected_quiet: assert property (@(posedge aclk) disable iff
      (!aresetn) ((alarm_source_clear_select & DCC_SRC_SEL_MASK) == '0)
      && software_dac_clear == '0 && pin0_clear_enable == '0
      |=> dac_clear == '0)
      else $error("dac cleared with no source selected");

   a_select_reserved: assert property (@(posedge aclk) disable iff
      (!aresetn) (alarm_source_clear_select & ~DCC_SRC_SEL_MASK) == '0)
      else $error("reserved select bits not zero");

   a_dac_reserved: assert property (@(posedge aclk) disable iff
      (!aresetn) ((auto_clear_enable | software_dac_clear
      | pin0_clear_enable) & ~DCC_DAC_MASK) == '0)
      else $error("reserved dac register bits not zero");

   // checked one edge after any reset edge, so no history is needed
   a_reset_values: assert property (@(posedge aclk)
      !aresetn |=> alarm_source_clear_select == DCC_SRC_SEL_RESET
      && auto_clear_enable == DCC_DAC_RESET
      && software_dac_clear == DCC_DAC_RESET
      && pin0_clear_enable == DCC_DAC_RESET)
      else $error("register reset value wrong");

   a_sw_clear_hold: assert property (@(posedge aclk) disable iff
      (!aresetn) software_dac_clear[DCC_DAC_LSB] [*2] |-> dac_clear[0])
      else $error("software clear did not hold dac 0 clear");

   a_pin_path: assert property (@(posedge aclk) disable iff
      (!aresetn) !external_clear_pin_0_n [*3]
      ##0 pin0_clear_enable[DCC_DAC_MSB] [*3] |=> dac_clear[NUM_DAC-1])
      else $error("pin clear did not reach dac 11");

   a_auto_gate: assert property (@(posedge aclk) disable iff
      (!aresetn) auto_clear_enable[DCC_DAC_LSB]
      && alarm_source_clear_select[DCC_SEL_IN3]
      && alarm_status_flags[DCC_SEL_IN3] |=> dac_clear[0])
      else $error("input 3 alarm did not clear dac 0");

   a_bresp_timing: assert property (@(posedge aclk) disable iff
      (!aresetn) do_write |=> s_axi_bvalid)
      else $error("write response not raised after commit");

   // main scenarios
   c_therm_clear: cover property (@(posedge aclk) disable iff
      (!aresetn) therm_hit ##1 &dac_clear);
   c_pin_clear: cover property (@(posedge aclk) disable iff
      (!aresetn) pin_active && dac_clear != '0);
   c_sw_release: cover property (@(posedge aclk) disable iff
      (!aresetn) dac_clear[0] ##1 !dac_clear[0]);
   c_slverr: cover property (@(posedge aclk) disable iff
      (!aresetn) s_axi_rvalid && s_axi_rresp == DCC_RESP_SLVERR);
endmodule
`default_nettype wire

/* tb/dcc_dac_clear_control_bench.sv */
// self-checking bench for the dac clear control register bank
`default_nettype none
module dcc_dac_clear_control_bench
   import dcc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0; // 20 mhz clock
   logic aresetn = 1'b0; // synchronous, active low
   logic [31:0] s_axi_awaddr = '0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [31:0] s_axi_araddr = '0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic [15:0] flags = '0; // alarm status levels
   logic pin_n = 1'b1; // clear pin idles high
   logic [11:0] dac_clear;
   // expected read answers and write responses, oldest first
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [11:0] cq[$]; // expected clear outputs, compared by the watcher
   logic [33:0] e_r;
   int n_fail = 0;
   int check_count = 0;
   integer seed = 21397;
   logic [31:0] r;
   // software view of the registers, kept from the writes we issue
   logic [15:0] sel = 16'h0004;
   logic [15:0] ae = '0;
   logic [15:0] sw = '0;
   logic [15:0] pe = '0;
   logic [9:0] amap[4];

   dcc_dac_clear_control i_dcc_dac_clear_control (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .alarm_status_flags(flags),
      .external_clear_pin_0_n(pin_n), .dac_clear(dac_clear)
   );

   // free-running clock, 50 ns period
   initial begin
      forever #25 aclk = ~aclk;
   end

   // one comparison, counted; mismatches reported at once
   task check(input string name, input logic [31:0] seen,
              input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // clear state worked out from the mirror and the driven inputs
   function logic [15:0] exp_clear();
      logic [15:0] h;
      h = {16{|(sel & flags & 16'h7ff8)}} & ae;
      h = h | {16{sel[2] & flags[2]}} | sw;
      if (pin_n === 1'b0) h = h | pe;
      return h & 16'h7ff8;
   endfunction

   task settle(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // one axi4-lite write; mirror follows the byte strobes
   task wr(input logic [9:0] a, input logic [15:0] d, input logic [3:0] st);
      logic [15:0] m;
      logic aw_ok;
      logic w_ok;
      int n;
      m = {{8{st[1]}}, {8{st[0]}}};
      case (a)
         DCC_ADDR_SRC_SEL: sel = (sel & ~m) | (d & m & 16'h7ffc);
         DCC_ADDR_AUTO_EN: ae = (ae & ~m) | (d & m & 16'h7ff8);
         DCC_ADDR_SW_CLR: sw = (sw & ~m) | (d & m & 16'h7ff8);
         DCC_ADDR_PIN0_EN: pe = (pe & ~m) | (d & m & 16'h7ff8);
         default: ;
      endcase
      bq.push_back((a == DCC_ADDR_CLR_STATE || a inside {amap}) ?
                   2'h0 : 2'h2);
      s_axi_awaddr <= {22'h0, a};
      s_axi_wdata <= {r[31:16], d};
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      n = 0;
      // each half released at its own handshake edge
      while (!(aw_ok && w_ok) && n < 100) begin
         @(posedge aclk);
         n++;
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 200);
      s_axi_bready <= 1'b0;
      if (n >= 200) check("write wait", 32'h0, 32'h1);
   endtask

   // one axi4-lite read; expectation queued for the watcher
   task rd(input logic [9:0] a);
      logic [15:0] e;
      int n;
      case (a)
         DCC_ADDR_SRC_SEL: e = sel;
         DCC_ADDR_AUTO_EN: e = ae;
         DCC_ADDR_SW_CLR: e = sw;
         DCC_ADDR_PIN0_EN: e = pe;
         DCC_ADDR_CLR_STATE: e = exp_clear();
         default: e = 16'h0;
      endcase
      rq.push_back({(a == DCC_ADDR_CLR_STATE || a inside {amap}) ?
                    2'h0 : 2'h2, 16'h0, e});
      s_axi_araddr <= {22'h0, a};
      s_axi_arvalid <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (s_axi_arready !== 1'b1 && n < 100);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 200);
      s_axi_rready <= 1'b0;
      if (n >= 200) check("read wait", 32'h0, 32'h1);
   endtask

   // watcher: each answer taken is compared with the oldest note
   always @(posedge aclk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         e_r = rq.pop_front();
         check("rdata", s_axi_rdata, e_r[31:0]);
         check("rresp", {30'h0, s_axi_rresp}, {30'h0, e_r[33:32]});
      end
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
         check("bresp", {30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
      end
      // clear levels are noted only while their causes stand still
      if (cq.size() > 0) begin
         check("clear", {20'h0, dac_clear}, {20'h0, cq.pop_front()});
      end
   end

   task give_verdict();
      if (n_fail == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // watchdog, far beyond the several hundred cycles the run needs
   initial begin
      #2000000;
      n_fail++;
      give_verdict();
   end

   // main sequence
   initial begin
      amap = '{DCC_ADDR_SRC_SEL, DCC_ADDR_AUTO_EN, DCC_ADDR_SW_CLR,
               DCC_ADDR_PIN0_EN};
      r = $random(seed);
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // reset values, then all-ones to expose fixed-zero bits
      foreach (amap[i]) rd(amap[i]);
      rd(DCC_ADDR_CLR_STATE);
      foreach (amap[i]) begin
         wr(amap[i], 16'hffff, 4'hf);
         rd(amap[i]);
      end
      wr(DCC_ADDR_SRC_SEL, 16'h0000, 4'h2); // high byte only
      rd(DCC_ADDR_SRC_SEL);
      wr(10'h160, 16'hffff, 4'hf); // unmapped place
      rd(10'h160);
      foreach (amap[i]) wr(amap[i], 16'h0000, 4'hf);
      // each non-thermal source alone, with unselected flags around it
      for (int b = 3; b <= 14; b++) begin
         r = $random(seed);
         wr(DCC_ADDR_SRC_SEL, 16'h1 << b, 4'hf);
         // dac 0 always enabled so the input 3 gate is exercised
         wr(DCC_ADDR_AUTO_EN, r[15:0] | 16'h0008, 4'hf);
         flags <= (16'h1 << b) | r[31:16];
         settle(2);
         rd(DCC_ADDR_CLR_STATE);
         wr(DCC_ADDR_SRC_SEL, 16'h0000, 4'hf);
         rd(DCC_ADDR_CLR_STATE);
      end
      // over-temperature overrides the per-dac enables
      wr(DCC_ADDR_AUTO_EN, 16'h0000, 4'hf);
      wr(DCC_ADDR_SRC_SEL, 16'h0004, 4'hf);
      flags <= 16'h0004;
      settle(2);
      cq.push_back(12'hfff);
      rd(DCC_ADDR_CLR_STATE);
      wr(DCC_ADDR_AUTO_EN, 16'hffff, 4'hf);
      wr(DCC_ADDR_SRC_SEL, 16'h0000, 4'hf);
      rd(DCC_ADDR_CLR_STATE);
      wr(DCC_ADDR_AUTO_EN, 16'h0000, 4'hf);
      flags <= 16'h0000;
      // software clear set then released
      wr(DCC_ADDR_SW_CLR, r[15:0] | 16'h0008, 4'hf);
      rd(DCC_ADDR_CLR_STATE);
      wr(DCC_ADDR_SW_CLR, 16'h0000, 4'hf);
      rd(DCC_ADDR_CLR_STATE);
      // pin clear, enabled then disabled while the pin stays low
      // dac 11 always enabled so the pin path reaches the top bit
      wr(DCC_ADDR_PIN0_EN, r[31:16] | 16'h4000, 4'hf);
      pin_n <= 1'b0;
      settle(5);
      rd(DCC_ADDR_CLR_STATE);
      wr(DCC_ADDR_PIN0_EN, 16'h0000, 4'hf);
      rd(DCC_ADDR_CLR_STATE);
      // random mixes of every source
      for (int k = 0; k < 16; k++) begin
         foreach (amap[i]) begin
            r = $random(seed);
            wr(amap[i], r[15:0], 4'hf);
         end
         r = $random(seed);
         flags <= r[15:0];
         pin_n <= r[16];
         settle(5);
         rd(DCC_ADDR_CLR_STATE);
         flags <= r[31:16];
         settle(2);
         r = {16'h0, exp_clear()};
         cq.push_back(r[14:3]);
      end
      settle(2);
      give_verdict();
   end
endmodule
`default_nettype wire
